// ---- gpp_map.svh ----
// register offsets, field positions and pad setup reset value of the pin port
`ifndef GPP_MAP_SVH
`define GPP_MAP_SVH
`define GPP_OUT_OFS 12'h504
`define GPP_OUTSET_OFS 12'h508
`define GPP_DRIVEN_LEVEL_CLEAR_OFS 12'h50C
`define GPP_IN_OFS 12'h510
`define GPP_DIR_OFS 12'h514
`define GPP_OUTPUT_ENABLE_SET_OFS 12'h518
`define GPP_OUTPUT_ENABLE_CLEAR_OFS 12'h51C
`define GPP_LATCH_OFS 12'h520
`define GPP_WAKESEL_OFS 12'h524
`define GPP_IRQ_STAT_OFS 12'h600
`define GPP_IRQ_MASK_OFS 12'h604
`define GPP_PAD_BASE 12'h700
`define GPP_PAD_LAST 12'h77C
`define GPP_PAD_RESET 32'h0000_0002
`define GPP_F_DIR 0
`define GPP_F_INBUF 1
`define GPP_F_PULL_LO 2
`define GPP_F_DRIVE_LO 8
`define GPP_F_SENSE_LO 16
`define GPP_PAD_MASK 32'h0003_070F
`define GPP_IRQ_DETECT 0
`define GPP_IRQ_CAPTURED_WAKE_FLAG 1
`endif

// ---- gpp_pkg.sv ----
// types shared by the pin port
package gpp_pkg;
   typedef enum logic [1:0] {
      GPP_SENSE_OFF = 2'b00,
      GPP_SENSE_RSV = 2'b01,
      GPP_SENSE_HIGH = 2'b10,
      GPP_SENSE_LOW = 2'b11
   } gpp_sense_e;
   typedef enum logic [1:0] {
      GPP_BUS_IDLE = 2'b00,
      GPP_BUS_ANSWER = 2'b01
   } gpp_bus_e;
endpackage

// ---- gpp_port.sv ----
// 32-pin general purpose port with avalon register slave
// How it works
// R1: writing ones to output clear drives those pins low; reads return output register
// R2: input register reports sampled level of each pin, read only
// R3: direction register, one is output, resets to zero
// R4: direction set writes ones make pins outputs; reads return direction
// R5: direction clear writes ones make pins inputs; reads return direction
// R6: capture flag per pin sets on sense match, write one clears, resets zero
// R7: wake source select chooses combined detects (0) or latched flags (1)
// R8: pad setup bit zero is the same storage as the direction bit
// R9: input buffer bit zero connects; pull field 0 none, 1 down, 3 up
// R10: drive field selects standard, high or off drive per level
// R11: sense 0 off, 2 high, 3 low; pad setup resets to 0x2
// R12: pins owned by the task/event unit ignore port output writes
// R13: released pins return at once to port's own output and setup
// R14: flag cannot clear while detect high; falling detect never clears it
// R15: latched detect high while any flag set; new rising edge after clear
// R16: input buffer must be connected for readback and sensing
// R17: unimplemented pins read zero and ignore writes
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "gpp_map.svh"
module gpp_port #(
   parameter logic [31:0] PIN_MASK = 32'hFFFF_FFFF
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [31:0] pad_in,
   output logic [31:0] pad_out,
   output logic [31:0] pad_oe,
   output logic [31:0] pad_pull_up,
   output logic [31:0] pad_pull_down,
   output logic [31:0] pad_high_drive,
   input wire logic [31:0] task_own,
   input wire logic [31:0] task_out,
   input wire logic [31:0] task_oe,
   output logic port_detect,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////
   logic rst_m;
   logic rst_s;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_m <= 1'b0;
         rst_s <= 1'b0;
      end else begin
         rst_m <= 1'b1;
         rst_s <= rst_m;
      end
   end

   ////////////////////////////////////////////////////////////////////
   logic [31:0] pin_m;
   logic [31:0] pin_s;
   logic [31:0] out_reg;
   logic [31:0] dir_reg;
   logic [1:0] pull_f [32];
   logic [2:0] drive_f [32];
   logic [1:0] sense_f [32];
   logic [31:0] inbuf_off;
   logic [31:0] latch_reg;
   logic wake_sel;
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   logic [31:0] det;
   logic ldet;
   logic ldet_gap;
   logic any_det_q;
   logic ldet_q;
   gpp_pkg::gpp_bus_e bus_st;
   logic [31:0] rdata;
   logic [31:0] wmask;
   logic wr;
   logic [4:0] pidx;
   logic pad_hit;

   function automatic logic [31:0] bytemask(input logic [3:0] be);
      bytemask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   function automatic logic [31:0] pad_word(input logic [4:0] i);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`GPP_F_DIR] = dir_reg[i];
      w[`GPP_F_INBUF] = inbuf_off[i];
      w[`GPP_F_PULL_LO +: 2] = pull_f[i];
      w[`GPP_F_DRIVE_LO +: 3] = drive_f[i];
      w[`GPP_F_SENSE_LO +: 2] = sense_f[i];
      pad_word = PIN_MASK[i] ? w : 32'h0000_0000; // R17
   endfunction

   assign wmask = bytemask(avs_byteenable) & PIN_MASK; // R17
   assign wr = avs_write && clk_en && (bus_st == gpp_pkg::GPP_BUS_ANSWER);
   assign pidx = avs_address[6:2];
   assign pad_hit = (avs_address >= `GPP_PAD_BASE) && (avs_address <= `GPP_PAD_LAST);

   // input sampled only through connected buffers
   always_ff @(posedge clk or negedge rst_s) begin
      if (!rst_s) begin
         pin_m <= 32'h0000_0000;
         pin_s <= 32'h0000_0000;
      end else if (clk_en) begin
         pin_m <= pad_in;
         pin_s <= pin_m & ~inbuf_off & PIN_MASK; // R16 R2
      end
   end

   ////////////////////////////////////////////////////////////////////
   // bus: one wait cycle gives registered read data
   always_ff @(posedge clk or negedge rst_s) begin
      if (!rst_s) begin
         bus_st <= gpp_pkg::GPP_BUS_IDLE;
      end else if (clk_en) begin
         case (bus_st)
            gpp_pkg::GPP_BUS_IDLE: begin
               if (avs_read || avs_write) begin
                  bus_st <= gpp_pkg::GPP_BUS_ANSWER;
               end
            end
            gpp_pkg::GPP_BUS_ANSWER: begin
               bus_st <= gpp_pkg::GPP_BUS_IDLE;
            end
            default: begin
               bus_st <= gpp_pkg::GPP_BUS_IDLE;
            end
         endcase
      end
   end
   assign avs_waitrequest = (avs_read || avs_write) && (bus_st != gpp_pkg::GPP_BUS_ANSWER);

   always_comb begin
      rdata = 32'h0000_0000;
      if (pad_hit) begin
         rdata = pad_word(pidx);
      end else begin
         case (avs_address)
            `GPP_OUT_OFS, `GPP_OUTSET_OFS, `GPP_DRIVEN_LEVEL_CLEAR_OFS: rdata = out_reg; // R1
            `GPP_IN_OFS: rdata = pin_s; // R2
            `GPP_DIR_OFS, `GPP_OUTPUT_ENABLE_SET_OFS, `GPP_OUTPUT_ENABLE_CLEAR_OFS: rdata = dir_reg; // R4 R5
            `GPP_LATCH_OFS: rdata = latch_reg;
            `GPP_WAKESEL_OFS: rdata = {31'h0000_0000, wake_sel};
            `GPP_IRQ_STAT_OFS: rdata = {30'h0000_0000, irq_stat};
            `GPP_IRQ_MASK_OFS: rdata = {30'h0000_0000, irq_mask};
            default: rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_s) begin
      if (!rst_s) begin
         avs_readdata <= 32'h0000_0000;
      end else if (clk_en && avs_read && bus_st == gpp_pkg::GPP_BUS_IDLE) begin
         avs_readdata <= rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // output register; owned pins keep their value
   always_ff @(posedge clk or negedge rst_s) begin
      if (!rst_s) begin
         out_reg <= 32'h0000_0000;
      end else if (wr) begin
         case (avs_address)
            `GPP_OUT_OFS: out_reg <= (out_reg & ~(wmask & ~task_own)) | (avs_writedata & wmask & ~task_own); // R12
            `GPP_OUTSET_OFS: out_reg <= out_reg | (avs_writedata & wmask & ~task_own); // R12
            `GPP_DRIVEN_LEVEL_CLEAR_OFS: out_reg <= out_reg & ~(avs_writedata & wmask & ~task_own); // R1 R12
            default: out_reg <= out_reg;
         endcase
      end
   end

   // direction bits shared by direction views and pad setup bit zero
   always_ff @(posedge clk or negedge rst_s) begin
      if (!rst_s) begin
         dir_reg <= 32'h0000_0000; // R3
      end else if (wr) begin
         if (pad_hit) begin
            if (PIN_MASK[pidx] && avs_byteenable[0]) begin
               dir_reg[pidx] <= avs_writedata[`GPP_F_DIR]; // R8
            end
         end else begin
            case (avs_address)
               `GPP_DIR_OFS: dir_reg <= (dir_reg & ~wmask) | (avs_writedata & wmask); // R3
               `GPP_OUTPUT_ENABLE_SET_OFS: dir_reg <= dir_reg | (avs_writedata & wmask); // R4
               `GPP_OUTPUT_ENABLE_CLEAR_OFS: dir_reg <= dir_reg & ~(avs_writedata & wmask); // R5
               default: dir_reg <= dir_reg;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rst_s) begin
      if (!rst_s) begin
         inbuf_off <= 32'hFFFF_FFFF & PIN_MASK; // R11
         for (int i = 0; i < 32; i++) begin
            pull_f[i] <= 2'h0;
            drive_f[i] <= 3'h0;
            sense_f[i] <= 2'h0;
         end
      end else if (wr && pad_hit && PIN_MASK[pidx]) begin // R17
         if (avs_byteenable[0]) begin
            inbuf_off[pidx] <= avs_writedata[`GPP_F_INBUF]; // R9
            pull_f[pidx] <= avs_writedata[`GPP_F_PULL_LO +: 2]; // R9
         end
         if (avs_byteenable[1]) begin
            drive_f[pidx] <= avs_writedata[`GPP_F_DRIVE_LO +: 3]; // R10
         end
         if (avs_byteenable[2]) begin
            sense_f[pidx] <= avs_writedata[`GPP_F_SENSE_LO +: 2]; // R11
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pad drive: owner unit overrides, release returns at once to port state
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         logic lvl;
         lvl = task_own[i] ? task_out[i] : out_reg[i]; // R12 R13
         pad_out[i] = lvl & PIN_MASK[i];
         pad_oe[i] = 1'b0;
         if (PIN_MASK[i] && (task_own[i] ? task_oe[i] : dir_reg[i])) begin // R13
            case (drive_f[i])
               3'h4, 3'h5: pad_oe[i] = lvl; // R10
               3'h6, 3'h7: pad_oe[i] = !lvl; // R10
               default: pad_oe[i] = 1'b1; // R10
            endcase
         end
         pad_high_drive[i] = PIN_MASK[i] && (lvl ? (drive_f[i] == 3'h2 || drive_f[i] == 3'h3 || drive_f[i] == 3'h5)
                                                : (drive_f[i] == 3'h1 || drive_f[i] == 3'h3 || drive_f[i] == 3'h7));
         pad_pull_up[i] = PIN_MASK[i] && pull_f[i] == 2'h3; // R9
         pad_pull_down[i] = PIN_MASK[i] && pull_f[i] == 2'h1; // R9
      end
   end

   ////////////////////////////////////////////////////////////////////
   // per-pin detect from synchronised, buffer-gated level
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         case (sense_f[i])
            gpp_pkg::GPP_SENSE_HIGH: det[i] = pin_s[i]; // R11 R16
            gpp_pkg::GPP_SENSE_LOW: det[i] = !pin_s[i] && !inbuf_off[i] && PIN_MASK[i]; // R11 R16
            default: det[i] = 1'b0; // R11
         endcase
      end
   end

   // set wins over clear; a high detect blocks the clear
   always_ff @(posedge clk or negedge rst_s) begin
      if (!rst_s) begin
         latch_reg <= 32'h0000_0000; // R6
      end else if (clk_en) begin
         if (wr && avs_address == `GPP_LATCH_OFS) begin
            latch_reg <= (latch_reg & ~(avs_writedata & wmask)) | det; // R6 R14
         end else begin
            latch_reg <= latch_reg | det; // R6 R14
         end
      end
   end

   // one low cycle after a clear that leaves flags set makes a new edge
   always_ff @(posedge clk or negedge rst_s) begin
      if (!rst_s) begin
         ldet_gap <= 1'b0;
      end else if (clk_en) begin
         ldet_gap <= wr && avs_address == `GPP_LATCH_OFS && |(avs_writedata & wmask & latch_reg); // R15
      end
   end
   assign ldet = |latch_reg && !ldet_gap; // R15

   always_ff @(posedge clk or negedge rst_s) begin
      if (!rst_s) begin
         wake_sel <= 1'b0;
      end else if (wr && avs_address == `GPP_WAKESEL_OFS && avs_byteenable[0]) begin
         wake_sel <= avs_writedata[0]; // R7
      end
   end
   assign port_detect = wake_sel ? ldet : |det; // R7

   ////////////////////////////////////////////////////////////////////
   // interrupts on rising combined detect and rising latched detect
   always_ff @(posedge clk or negedge rst_s) begin
      if (!rst_s) begin
         any_det_q <= 1'b0;
         ldet_q <= 1'b0;
         irq_stat <= 2'h0;
         irq_mask <= 2'h0;
      end else if (clk_en) begin
         any_det_q <= |det;
         ldet_q <= ldet;
         if (wr && avs_address == `GPP_IRQ_MASK_OFS && avs_byteenable[0]) begin
            irq_mask <= avs_writedata[1:0];
         end
         irq_stat <= (irq_stat & ~((wr && avs_address == `GPP_IRQ_STAT_OFS && avs_byteenable[0])
                      ? avs_writedata[1:0] : 2'h0)) | {ldet && !ldet_q, |det && !any_det_q};
      end
   end
   assign irq = |(irq_stat & irq_mask);

   ////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_s);

   latch_holds_a: assert property (clk_en && |(latch_reg & det) |=> |latch_reg) // R14
      else $error("latch flag cleared while detect high");
   latch_sets_a: assert property (clk_en && det[0] |=> latch_reg[0]) // R6
      else $error("detect did not set capture flag");
   latch_clear_a: assert property (clk_en && wr && avs_address == `GPP_LATCH_OFS && avs_writedata[0] && wmask[0]
      && !det[0] |=> !latch_reg[0]) // R6
      else $error("capture flag not cleared");
   driven_level_clear_low_a: assert property (wr && avs_address == `GPP_DRIVEN_LEVEL_CLEAR_OFS && avs_writedata[0] && wmask[0]
      && !task_own[0] |=> !out_reg[0]) // R1
      else $error("output clear ignored");
   owned_keep_a: assert property (wr && task_own[4] |=> $stable(out_reg[4])) // R12
      else $error("owned pin output changed");
   output_enable_set_a: assert property (wr && avs_address == `GPP_OUTPUT_ENABLE_SET_OFS && avs_writedata[2] && wmask[2]
      |=> dir_reg[2]) // R4
      else $error("direction set ignored");
   output_enable_clear_a: assert property (wr && avs_address == `GPP_OUTPUT_ENABLE_CLEAR_OFS && avs_writedata[2] && wmask[2]
      |=> !dir_reg[2]) // R5
      else $error("direction clear ignored");
   pad_dir_a: assert property (wr && pad_hit && pidx == 5'd1 && avs_byteenable[0] && PIN_MASK[1]
      |=> dir_reg[1] == $past(avs_writedata[0])) // R8
      else $error("pad setup direction not shared");
   ldet_src_a: assert property (wake_sel && |latch_reg && !ldet_gap |-> port_detect) // R7 R15
      else $error("latched detect not driven");
   release_a: assert property (!task_own[4] |-> pad_out[4] == (out_reg[4] & PIN_MASK[4])) // R13
      else $error("released pin not on port value");
   cov_clear_rearm: cover property (ldet_gap ##1 ldet);
   cov_irq: cover property (irq);
   cov_owned_write: cover property (wr && |task_own);
endmodule

// ---- gpp_port_tb_top.sv ----
// self-checking bench for the 32-pin port
`timescale 1ns/1ps
`include "gpp_map.svh"
module gpp_port_tb_top;
   // top pin left out to reach the unimplemented-pin path
   localparam logic [31:0] PIN_MASK = 32'h7FFF_FFFF;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic clk_en = 1'b1;
   logic [11:0] avs_address = 12'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [31:0] pad_in = 32'h0000_0000;
   logic [31:0] pad_out;
   logic [31:0] pad_oe;
   logic [31:0] pad_pull_up;
   logic [31:0] pad_pull_down;
   logic [31:0] pad_high_drive;
   logic [31:0] task_own = 32'h0000_0000;
   logic [31:0] task_out = 32'h0000_0000;
   logic [31:0] task_oe = 32'h0000_0000;
   logic port_detect;
   logic irq;
   int bad_count = 0;
   int checks_done = 0;
   logic [31:0] rd;

   gpp_port #(.PIN_MASK(PIN_MASK)) u_gpp_port (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
      .pad_pull_down(pad_pull_down), .pad_high_drive(pad_high_drive), .task_own(task_own),
      .task_out(task_out), .task_oe(task_oe), .port_detect(port_detect), .irq(irq));

   always #2 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // waitrequest and read data are taken at the rising edge that ends the wait
   task automatic bus(input logic wr, input logic [11:0] adr, input logic [31:0] wd);
      int n;
      logic ok;
      n = 0;
      ok = 1'b0;
      @(posedge clk);
      avs_address <= adr;
      avs_writedata <= wd;
      avs_read <= !wr;
      avs_write <= wr;
      while (!ok && n < 50) begin
         @(posedge clk);
         ok = !avs_waitrequest;
         rd = avs_readdata;
         n++;
      end
      if (!ok) begin
         bad_count++;
         $display("ERROR bus answer expected 1 seen 0");
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] adr, input logic [31:0] wd);
      bus(1'b1, adr, wd);
   endtask

   task automatic rc(input string what, input logic [11:0] adr, input logic [31:0] exp);
      bus(1'b0, adr, 32'h0000_0000);
      chk(what, exp, rd);
   endtask

   function automatic logic [11:0] pa(input int n);
      return `GPP_PAD_BASE + 12'(4 * n);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rc("dir", `GPP_DIR_OFS, 32'h0000_0000);
      rc("latch", `GPP_LATCH_OFS, 32'h0000_0000);
      rc("wakesel", `GPP_WAKESEL_OFS, 32'h0000_0000);
      rc("pad0", pa(0), 32'h0000_0002);
      chk("oe", 32'h0000_0000, pad_oe);
      $display("reset test done");
   endtask

   task automatic t_regs;
      wr(`GPP_OUT_OFS, 32'hFFFF_FFFF);
      wr(`GPP_DRIVEN_LEVEL_CLEAR_OFS, 32'h0000_00F0);
      rc("driven_level_clear", `GPP_DRIVEN_LEVEL_CLEAR_OFS, 32'h7FFF_FF0F);
      wr(`GPP_OUTPUT_ENABLE_SET_OFS, 32'hFFFF_FFFF);
      rc("output_enable_set", `GPP_OUTPUT_ENABLE_SET_OFS, 32'h7FFF_FFFF);
      @(negedge clk);
      chk("pad_out", 32'h7FFF_FF0F, pad_out & PIN_MASK);
      wr(`GPP_OUTPUT_ENABLE_CLEAR_OFS, 32'h0000_000F);
      rc("output_enable_clear", `GPP_OUTPUT_ENABLE_CLEAR_OFS, 32'h7FFF_FFF0);
      rc("pad4", pa(4), 32'h0000_0003);
      wr(pa(0), 32'h0000_0001);
      rc("dir", `GPP_DIR_OFS, 32'h7FFF_FFF1);
      rc("pad31", pa(31), 32'h0000_0000);
      rc("unmapped", 12'h530, 32'h0000_0000);
      wr(`GPP_DIR_OFS, 32'h0000_0000);
      rc("dir", `GPP_DIR_OFS, 32'h0000_0000);
      $display("register test done");
   endtask

   task automatic t_pad;
      for (int d = 0; d < 8; d++) begin
         wr(pa(5), 32'h0000_000C | (32'(d) << 8));
         rc("drive", pa(5), 32'h0000_000C | (32'(d) << 8));
         chk("high_drive", 32'(d == 1 || d == 3 || d == 7), 32'(pad_high_drive[5]));
      end
      @(negedge clk);
      chk("pull_up", 32'h0000_0001, 32'(pad_pull_up[5]));
      wr(pa(5), 32'h0000_0004);
      @(negedge clk);
      chk("pull_down", 32'h0000_0001, 32'(pad_pull_down[5] & !pad_pull_up[5]));
      wr(pa(5), 32'h0000_0000);
      @(negedge clk);
      chk("no_pull", 32'h0000_0000, 32'(pad_pull_down[5] | pad_pull_up[5]));
      $display("pad test done");
   endtask

   task automatic t_in;
      @(posedge clk);
      pad_in <= 32'h0000_00A5;
      for (int i = 0; i < 8; i++) begin
         wr(pa(i), 32'h0000_0000);
      end
      repeat (4) @(posedge clk);
      bus(1'b0, `GPP_IN_OFS, 32'h0000_0000);
      chk("in", 32'h0000_00A5, rd & 32'h0000_00FF);
      @(posedge clk);
      pad_in <= 32'h0000_0000;
      $display("input test done");
   endtask

   task automatic t_sense;
      wr(pa(1), 32'h0002_0000);
      pad_in[1] <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("detect", 32'h0000_0001, 32'(port_detect));
      rc("latch", `GPP_LATCH_OFS, 32'h0000_0002);
      wr(`GPP_LATCH_OFS, 32'h0000_0002);
      rc("latch_held", `GPP_LATCH_OFS, 32'h0000_0002);
      @(posedge clk);
      pad_in[1] <= 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("detect", 32'h0000_0000, 32'(port_detect));
      rc("latch_fall", `GPP_LATCH_OFS, 32'h0000_0002);
      wr(`GPP_WAKESEL_OFS, 32'h0000_0001);
      rc("wakesel", `GPP_WAKESEL_OFS, 32'h0000_0001);
      chk("captured_wake_flag", 32'h0000_0001, 32'(port_detect));
      wr(`GPP_LATCH_OFS, 32'h0000_0002);
      rc("latch_clr", `GPP_LATCH_OFS, 32'h0000_0000);
      chk("captured_wake_flag", 32'h0000_0000, 32'(port_detect));
      wr(`GPP_IRQ_MASK_OFS, 32'h0000_0002);
      wr(`GPP_IRQ_STAT_OFS, 32'h0000_0003);
      pad_in[1] <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("irq", 32'h0000_0001, 32'(irq));
      wr(`GPP_IRQ_STAT_OFS, 32'h0000_0002);
      @(negedge clk);
      chk("irq", 32'h0000_0000, 32'(irq));
      // clearing a flag whose pin still detects must give a fresh edge
      wr(`GPP_LATCH_OFS, 32'h0000_0002);
      repeat (3) @(posedge clk);
      bus(1'b0, `GPP_IRQ_STAT_OFS, 32'h0000_0000);
      chk("re_edge", 32'h0000_0002, rd & 32'h0000_0002);
      chk("irq", 32'h0000_0001, 32'(irq));
      wr(`GPP_IRQ_MASK_OFS, 32'h0000_0000);
      @(negedge clk);
      chk("irq_masked", 32'h0000_0000, 32'(irq));
      // pin 2 is low: low sense matches at once
      wr(pa(2), 32'h0003_0000);
      repeat (4) @(posedge clk);
      rc("latch_low", `GPP_LATCH_OFS, 32'h0000_0006);
      wr(pa(1), 32'h0000_0002);
      wr(pa(2), 32'h0000_0002);
      wr(`GPP_LATCH_OFS, 32'h0000_0006);
      rc("latch_off", `GPP_LATCH_OFS, 32'h0000_0000);
      wr(`GPP_WAKESEL_OFS, 32'h0000_0000);
      $display("sense test done");
   endtask

   task automatic t_task;
      wr(`GPP_OUTPUT_ENABLE_SET_OFS, 32'h0000_0010);
      wr(`GPP_OUTSET_OFS, 32'h0000_0010);
      task_own <= 32'h0000_0010;
      wr(`GPP_DRIVEN_LEVEL_CLEAR_OFS, 32'h0000_0010);
      @(negedge clk);
      chk("owned_out", 32'h0000_0000, 32'(pad_out[4]));
      chk("owned_oe", 32'h0000_0000, 32'(pad_oe[4]));
      @(posedge clk);
      task_own <= 32'h0000_0000;
      @(negedge clk);
      chk("released_out", 32'h0000_0001, 32'(pad_out[4]));
      chk("released_oe", 32'h0000_0001, 32'(pad_oe[4]));
      $display("task unit test done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_regs();
      t_pad();
      t_in();
      t_sense();
      t_task();
      finish_test();
   end

   // the whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      finish_test();
   end
endmodule
